// >>> design/sfu_pkg.sv
// Shared constants and types for the status word and serial receiver
package sfu_pkg;

   // Status word bit positions
   localparam int STAT_CARRY      = 15;
   localparam int STAT_POSITIVE   = 14;
   localparam int STAT_ZERO       = 13;
   localparam int STAT_NEGATIVE   = 12;
   localparam int STAT_OVERFLOW   = 11;
   localparam int STAT_NORMALIZED = 10;
   localparam int STAT_IRQ_EN     = 9;
   localparam int STAT_DISC_ONE   = 8;
   localparam int STAT_RX_ERROR   = 7;
   localparam int STAT_OVERRUN    = 6;
   localparam int STAT_FRAMING    = 5;
   localparam int STAT_PARITY     = 4;
   localparam int STAT_DISC_TWO   = 3;
   localparam int STAT_TX_HOLD    = 2;
   localparam int STAT_TX_SHIFT   = 1;
   localparam int STAT_RX_READY   = 0;

   // Register select on the input-register instruction
   localparam logic SEL_STATUS = 1'b0;
   localparam logic SEL_SERIAL_RECEIVE_BUFFER   = 1'b1;

   localparam logic [7:0]  SERIAL_RECEIVE_BUFFER_UPPER_ZERO = 8'h00;
   localparam logic [7:0]  RX_BYTE_RESET   = 8'h00;

   // Pin synchroniser lanes and their idle levels
   localparam int PIN_RX    = 0;
   localparam int PIN_TIMER = 1;
   localparam int PIN_DI1   = 2;
   localparam int PIN_DI2   = 3;
   localparam logic [3:0] PIN_STABLE_RESET = 4'h1;

   // Timing
   localparam int CLK_HZ           = 50_000_000;
   localparam int TIMER_CLK_HZ     = 12_000_000;
   localparam int BAUD             = 9600;
   localparam int OVERSAMPLE       = 10;
   localparam int TICKS_PER_SAMPLE = TIMER_CLK_HZ / (BAUD * OVERSAMPLE);
   localparam int MID_SAMPLE       = OVERSAMPLE / 2;
   localparam int TICK_CNT_W       = 7;
   localparam logic [TICK_CNT_W-1:0] TICK_LAST =
      TICK_CNT_W'(TICKS_PER_SAMPLE - 1);
   localparam logic [3:0] SAMPLE_LAST = 4'(OVERSAMPLE - 1);
   localparam logic [3:0] MID_LAST    = 4'(MID_SAMPLE - 1);
   localparam logic [2:0] DATA_LAST   = 3'h7;

   // Received frame word: {stop_bad, parity_bad, byte}
   localparam int FRAME_W     = 10;
   localparam int FRAME_STOP  = 9;
   localparam int FRAME_PAR   = 8;
   localparam int FIFO_DEPTH  = 16;

   typedef enum logic [2:0] {
      RX_IDLE   = 3'b000,
      RX_START  = 3'b001,
      RX_DATA   = 3'b010,
      RX_PARITY = 3'b011,
      RX_STOP   = 3'b100
   } sfu_rx_state_type;

endpackage

// >>> design/sfu_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sfu_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             arst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_check
      $error("sfu_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   wire              push;
   wire              pop;

   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_reg[rd_ptr_reg];

   always_ff @(posedge clock) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + AW'(push);
         rd_ptr_reg <= rd_ptr_reg + AW'(pop);
         count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// >>> design/sfu_rx.sv
// Oversampling deserialiser for one start, eight data, parity, stop
`timescale 1ns/1ps
module sfu_rx
   import sfu_pkg::*;
(
   input  wire logic               clock,
   input  wire logic               arst_n,
   input  wire logic               sample_tick,
   input  wire logic               rx_level,
   output logic                    frame_valid,
   output logic [sfu_pkg::FRAME_W-1:0] frame_word
);
   sfu_rx_state_type state_reg;
   sfu_rx_state_type state_next;
   logic [3:0] cnt_reg;
   logic [2:0] bit_reg;
   logic [7:0] shift_reg;
   logic       par_reg;
   logic       prev_reg;
   logic       valid_reg;
   logic [FRAME_W-1:0] word_reg;

   wire falling   = prev_reg & ~rx_level;
   wire at_mid    = (cnt_reg == MID_LAST);
   wire at_last   = (cnt_reg == SAMPLE_LAST);
   wire odd_ok    = ^{shift_reg, par_reg};

   assign frame_valid = valid_reg;
   assign frame_word  = word_reg;

   always_comb begin
      state_next = state_reg;
      if (sample_tick) begin
         unique case (state_reg)
            RX_IDLE:   if (falling) state_next = RX_START;
            RX_START: begin
               if (at_mid) begin
                  state_next = rx_level ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (at_last && bit_reg == DATA_LAST) begin
                  state_next = RX_PARITY;
               end
            end
            RX_PARITY: if (at_last) state_next = RX_STOP;
            RX_STOP:   if (at_last) state_next = RX_IDLE;
            default:   state_next = RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= RX_IDLE;
         cnt_reg   <= '0;
         bit_reg   <= '0;
         shift_reg <= '0;
         par_reg   <= 1'b0;
         prev_reg  <= 1'b1;
         valid_reg <= 1'b0;
         word_reg  <= '0;
      end else begin
         state_reg <= state_next;
         valid_reg <= 1'b0;
         if (sample_tick) begin
            prev_reg <= rx_level;
            // Restart the bit-phase count at each boundary
            if (state_next != state_reg || at_last) begin
               cnt_reg <= '0;
            end else begin
               cnt_reg <= cnt_reg + 4'h1;
            end
            if (state_reg == RX_START) begin
               bit_reg <= '0;
            end
            if (state_reg == RX_DATA && at_last) begin
               shift_reg <= {rx_level, shift_reg[7:1]};
               bit_reg   <= bit_reg + 3'h1;
            end
            if (state_reg == RX_PARITY && at_last) begin
               par_reg <= rx_level;
            end
            if (state_reg == RX_STOP && at_last) begin
               valid_reg <= 1'b1;
               word_reg  <= {~rx_level, ~odd_ok, shift_reg};
            end
         end
      end
   end
endmodule

// >>> design/sfu_status_rx.sv
// System status word and serial receive buffer register bank
`timescale 1ns/1ps
module sfu_status_rx
   import sfu_pkg::*;
#(
   parameter int RX_FIFO_DEPTH = sfu_pkg::FIFO_DEPTH
) (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        serial_rx_pin,
   input  wire logic        timer_clock_input,
   input  wire logic        discrete_input_one,
   input  wire logic        discrete_input_two,
   input  wire logic        tx_holding_empty,
   input  wire logic        tx_shifter_empty,
   input  wire logic        irq_enable_command,
   input  wire logic        irq_disable_command,
   input  wire logic        flag_update,
   input  wire logic        long_op,
   input  wire logic        dest_msb,
   input  wire logic        src_msb,
   input  wire logic [31:0] op_result,
   input  wire logic        input_register_instruction,
   input  wire logic        reg_select,
   output logic      [15:0] read_data,
   output logic             read_valid,
   output logic             irq_enabled
);
   import sfu_pkg::*;

   if (TICKS_PER_SAMPLE < 2 || TICKS_PER_SAMPLE >= (1 << TICK_CNT_W))
   begin : g_check
      $error("sfu_status_rx: timer divider out of range");
   end

   if (RX_FIFO_DEPTH < 2 || (RX_FIFO_DEPTH & (RX_FIFO_DEPTH - 1)) != 0)
   begin : g_depth_check
      $error("sfu_status_rx: receive buffer depth must be a power of two");
   end

   function automatic logic carry_eq(input logic d, input logic s,
                                     input logic r);
      carry_eq = (~d & ~s & ~r) | (d & ~s & r) | (d & s & r)
               | (d & s & ~r);
   endfunction

   function automatic logic overflow_eq(input logic d, input logic s,
                                        input logic r);
      overflow_eq = (~d & s & ~r) | (d & ~s & r);
   endfunction

   // Pin synchronisers: three stages, a change counts once 2 and 3 agree
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic [3:0] sync3_reg;
   logic [3:0] stable_reg;
   wire  [3:0] pins = {discrete_input_two, discrete_input_one,
                       timer_clock_input, serial_rx_pin};
   wire  [3:0] agree = ~(sync2_reg ^ sync3_reg);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg  <= PIN_STABLE_RESET;
         sync2_reg  <= PIN_STABLE_RESET;
         sync3_reg  <= PIN_STABLE_RESET;
      end else begin
         sync1_reg  <= pins;
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
      end
   end

   // Hold the last agreed level while stages 2 and 3 disagree
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stable_reg <= PIN_STABLE_RESET;
      end else begin
         stable_reg <= (agree & sync3_reg) | (~agree & stable_reg);
      end
   end

   // Sample tick from timer clock edges; 12 MHz / 125 = 10x 9600 baud
   logic                  timer_prev_reg;
   logic [TICK_CNT_W-1:0] div_reg;
   logic                  tick_reg;
   wire                   timer_rise = stable_reg[PIN_TIMER] &
                                       ~timer_prev_reg;
   wire                   div_wrap   = timer_rise & (div_reg == TICK_LAST);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         timer_prev_reg <= 1'b0;
         div_reg        <= '0;
         tick_reg       <= 1'b0;
      end else begin
         timer_prev_reg <= stable_reg[PIN_TIMER];
         tick_reg       <= div_wrap;
         if (div_wrap) begin
            div_reg <= '0;
         end else if (timer_rise) begin
            div_reg <= div_reg + TICK_CNT_W'(1);
         end
      end
   end

   // Receiver and frame buffer
   logic               frame_valid;
   logic [FRAME_W-1:0] frame_word;
   logic               fifo_in_ready;
   logic               fifo_out_ready;
   logic               fifo_out_valid;
   logic [FRAME_W-1:0] fifo_out_data;

   sfu_rx u_rx (
      .clock       (clock),
      .arst_n      (arst_n),
      .sample_tick (tick_reg),
      .rx_level    (stable_reg[PIN_RX]),
      .frame_valid (frame_valid),
      .frame_word  (frame_word)
   );

   // The line cannot be stalled: a frame meeting a full buffer is lost
   sfu_fifo #(
      .WIDTH (FRAME_W),
      .DEPTH (RX_FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .arst_n    (arst_n),
      .in_valid  (frame_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (frame_word),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // Read decode
   wire serial_receive_buffer_read   = input_register_instruction & (reg_select == SEL_SERIAL_RECEIVE_BUFFER);
   wire status_read = input_register_instruction &
                      (reg_select == SEL_STATUS);

   // Receive holding register drains the buffer when empty or being read
   logic       ready_reg;
   logic       overrun_reg;
   logic       framing_reg;
   logic       parity_reg;
   logic [7:0] rx_byte_reg;
   assign fifo_out_ready = ~ready_reg | serial_receive_buffer_read;
   wire        load_word      = fifo_out_valid & fifo_out_ready;
   wire        word_lost      = frame_valid & ~fifo_in_ready;

   wire ready_next   = load_word | (ready_reg & ~serial_receive_buffer_read);
   wire overrun_next = word_lost | (overrun_reg & ~serial_receive_buffer_read);
   wire framing_next = load_word ? fifo_out_data[FRAME_STOP]
                                 : framing_reg;
   wire parity_next  = load_word ? fifo_out_data[FRAME_PAR]
                                 : parity_reg;
   wire [7:0] rx_byte_next = load_word ? fifo_out_data[7:0]
                                       : rx_byte_reg;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ready_reg   <= 1'b0;
         overrun_reg <= 1'b0;
         framing_reg <= 1'b0;
         parity_reg  <= 1'b0;
      end else begin
         ready_reg   <= ready_next;
         overrun_reg <= overrun_next;
         framing_reg <= framing_next;
         parity_reg  <= parity_next;
      end
   end

   // Empty buffer reads return the last byte, or zero before the first frame after reset
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_byte_reg <= RX_BYTE_RESET;
      end else begin
         rx_byte_reg <= rx_byte_next;
      end
   end

   // Condition flags
   logic carry_reg;
   logic positive_reg;
   logic zero_reg;
   logic negative_reg;
   logic overflow_reg;
   logic normalized_reg;
   logic irq_en_reg;

   wire res_msb   = long_op ? op_result[31] : op_result[15];
   wire res_zero  = long_op ? (op_result == 32'h0000_0000)
                            : (op_result[15:0] == 16'h0000);
   wire carry_n   = carry_eq(dest_msb, src_msb, res_msb);
   wire ovf_n     = overflow_eq(dest_msb, src_msb, res_msb);
   wire pos_n     = ~res_msb & ~res_zero;
   wire norm_n    = op_result[31] ^ op_result[30];
   // Set and clear at once: set wins so the enable is not dropped
   wire irq_en_next = irq_enable_command |
                      (irq_en_reg & ~irq_disable_command);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         irq_en_reg <= 1'b0;
      end else begin
         irq_en_reg <= irq_en_next;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         carry_reg    <= 1'b0;
         positive_reg <= 1'b0;
         zero_reg     <= 1'b0;
         negative_reg <= 1'b0;
         overflow_reg <= 1'b0;
      end else if (flag_update) begin
         carry_reg    <= carry_n;
         positive_reg <= pos_n;
         zero_reg     <= res_zero;
         negative_reg <= res_msb;
         overflow_reg <= ovf_n;
      end
   end

   // Short operations leave the normalized flag untouched
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         normalized_reg <= 1'b0;
      end else if (flag_update && long_op) begin
         normalized_reg <= norm_n;
      end
   end

   // Status word
   logic [15:0] status_word;
   assign status_word[STAT_CARRY]      = carry_reg;
   assign status_word[STAT_POSITIVE]   = positive_reg;
   assign status_word[STAT_ZERO]       = zero_reg;
   assign status_word[STAT_NEGATIVE]   = negative_reg;
   assign status_word[STAT_OVERFLOW]   = overflow_reg;
   assign status_word[STAT_NORMALIZED] = normalized_reg;
   assign status_word[STAT_IRQ_EN]     = irq_en_reg;
   assign status_word[STAT_DISC_ONE]   = stable_reg[PIN_DI1];
   assign status_word[STAT_RX_ERROR]   = overrun_reg | framing_reg |
                                         parity_reg;
   assign status_word[STAT_OVERRUN]    = overrun_reg;
   assign status_word[STAT_FRAMING]    = framing_reg;
   assign status_word[STAT_PARITY]     = parity_reg;
   assign status_word[STAT_DISC_TWO]   = stable_reg[PIN_DI2];
   assign status_word[STAT_TX_HOLD]    = tx_holding_empty;
   assign status_word[STAT_TX_SHIFT]   = tx_shifter_empty;
   assign status_word[STAT_RX_READY]   = ready_reg;

   // Read port
   logic [15:0] read_data_reg;
   logic        read_valid_reg;
   wire  [15:0] serial_receive_buffer_word = {SERIAL_RECEIVE_BUFFER_UPPER_ZERO, rx_byte_reg};

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         read_valid_reg <= 1'b0;
      end else begin
         read_valid_reg <= input_register_instruction;
      end
   end

   // Data holds between requests so a late reader still sees it
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         read_data_reg <= 16'h0000;
      end else if (serial_receive_buffer_read) begin
         read_data_reg <= serial_receive_buffer_word;
      end else if (status_read) begin
         read_data_reg <= status_word;
      end
   end

   assign read_data   = read_data_reg;
   assign read_valid  = read_valid_reg;
   assign irq_enabled = irq_en_reg;
endmodule

// >>> test/sfu_status_rx_asserts.sv
// Port-level checks for the status word and receive buffer bank
`timescale 1ns/1ps
module sfu_status_rx_asserts
   import sfu_pkg::*;
#(
   parameter int RX_FIFO_DEPTH = sfu_pkg::FIFO_DEPTH
) (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        tx_holding_empty,
   input wire logic        tx_shifter_empty,
   input wire logic        irq_enable_command,
   input wire logic        irq_disable_command,
   input wire logic        flag_update,
   input wire logic        long_op,
   input wire logic        dest_msb,
   input wire logic        src_msb,
   input wire logic [31:0] op_result,
   input wire logic        input_register_instruction,
   input wire logic        reg_select,
   input wire logic [15:0] read_data,
   input wire logic        read_valid,
   input wire logic        irq_enabled
);
   logic rm;
   logic zero_c;
   logic pos_c;
   logic carry_c;
   logic over_c;
   logic norm_c;

   assign rm      = long_op ? op_result[31] : op_result[15];
   assign zero_c  = long_op ? (op_result == 32'h0000_0000)
                            : (op_result[15:0] == 16'h0000);
   assign pos_c   = !rm && !zero_c;
   // Both-signs-set terms of the carry sum collapse to D and S
   assign carry_c = (!dest_msb && !src_msb && !rm)
                    || (dest_msb && !src_msb && rm) || (dest_msb && src_msb);
   assign over_c  = (!dest_msb && src_msb && !rm)
                    || (dest_msb && !src_msb && rm);
   assign norm_c  = op_result[31] ^ op_result[30];

   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence stat_rd;
      input_register_instruction && reg_select == SEL_STATUS;
   endsequence
   sequence upd_rd;
      flag_update ##1 stat_rd;
   endsequence

   chk_read_answer: assert property (
      input_register_instruction |=> read_valid) else $error("no answer");
   chk_serial_receive_buffer_upper: assert property (
      input_register_instruction && reg_select == SEL_SERIAL_RECEIVE_BUFFER |=>
      read_data[15:8] == SERIAL_RECEIVE_BUFFER_UPPER_ZERO) else $error("upper byte");
   chk_carry_flag: assert property (
      upd_rd |=> read_data[STAT_CARRY] == $past(carry_c, 2)) else $error("C");
   chk_positive_flag: assert property (
      upd_rd |=> read_data[STAT_POSITIVE] == $past(pos_c, 2)) else $error("P");
   chk_zero_flag: assert property (
      upd_rd |=> read_data[STAT_ZERO] == $past(zero_c, 2)) else $error("Z");
   chk_negative_flag: assert property (
      upd_rd |=> read_data[STAT_NEGATIVE] == $past(rm, 2)) else $error("N");
   chk_overflow_flag: assert property (
      upd_rd |=> read_data[STAT_OVERFLOW] == $past(over_c, 2)) else $error("V");
   chk_norm_flag: assert property (
      flag_update && long_op ##1 stat_rd |=>
      read_data[STAT_NORMALIZED] == $past(norm_c, 2)) else $error("J");
   chk_irq_set: assert property (
      irq_enable_command |=> irq_enabled) else $error("irq set");
   chk_irq_clear: assert property (
      irq_disable_command && !irq_enable_command |=> !irq_enabled)
      else $error("irq clear");
   chk_error_sum: assert property (
      stat_rd |=> read_data[STAT_RX_ERROR] ==
      (|read_data[STAT_OVERRUN:STAT_PARITY])) else $error("error sum");
   chk_tx_hold: assert property (
      stat_rd |=> read_data[STAT_TX_HOLD] == $past(tx_holding_empty))
      else $error("tx hold");
   chk_tx_shift: assert property (
      stat_rd |=> read_data[STAT_TX_SHIFT] == $past(tx_shifter_empty))
      else $error("tx shift");
endmodule

bind sfu_status_rx sfu_status_rx_asserts #(.RX_FIFO_DEPTH(RX_FIFO_DEPTH))
   sfu_status_rx_asserts_i (.clock(clock), .arst_n(arst_n),
   .tx_holding_empty(tx_holding_empty), .tx_shifter_empty(tx_shifter_empty),
   .irq_enable_command(irq_enable_command), .long_op(long_op),
   .irq_disable_command(irq_disable_command), .flag_update(flag_update),
   .dest_msb(dest_msb), .src_msb(src_msb), .op_result(op_result),
   .input_register_instruction(input_register_instruction),
   .reg_select(reg_select), .read_data(read_data),
   .read_valid(read_valid), .irq_enabled(irq_enabled));

// >>> test/sfu_serial_sender.sv
// Remote asynchronous serial sender feeding the receive pin
`timescale 1ns/1ps
module sfu_serial_sender #(
   parameter real BIT_NS = 104166.667
) (
   output logic serial_line
);
   initial serial_line = 1'b1;

   // Parity or stop may be spoiled on purpose for error cases
   task automatic send(input logic [7:0] data, input logic par_ok,
                       input logic stop_ok);
      logic [10:0] frame;
      frame = {stop_ok, par_ok ^ (^data), data, 1'b0};
      for (int i = 0; i < 11; i++) begin
         serial_line = frame[i];
         #(BIT_NS);
      end
      serial_line = 1'b1;
   endtask
endmodule

// >>> test/sfu_status_rx_tb.sv
// Self-checking bench for the status word and receive buffer bank
`timescale 1ns/1ps
module sfu_status_rx_tb;
   import sfu_pkg::*;

   typedef struct {
      logic        lng, dm, sm, th, ts;
      logic [31:0] res;
      logic [5:0]  flags;
   } sfu_row_type;

   sfu_row_type rows [6] = '{
      '{0, 0, 0, 1, 0, 32'h0000_0000, 6'h28},
      '{0, 1, 0, 0, 1, 32'h0000_8000, 6'h26},
      '{0, 0, 1, 1, 1, 32'h0000_0001, 6'h12},
      '{1, 1, 1, 0, 0, 32'h4000_0000, 6'h31},
      '{0, 0, 0, 1, 0, 32'h4000_0000, 6'h29},
      '{1, 0, 0, 0, 1, 32'h0001_0000, 6'h30}};

   logic        clock, arst_n, rx_line, timer, di1, di2, th, ts;
   logic        irq_en, irq_dis, upd, lng, dm, sm, req, sel;
   logic [31:0] res;
   logic [15:0] read_data, d;
   logic        read_valid, irq_enabled;
   int          n_mismatch, check_count, n;

   sfu_status_rx sfu_status_rx_i (.clock(clock), .arst_n(arst_n),
      .serial_rx_pin(rx_line), .timer_clock_input(timer),
      .discrete_input_one(di1), .discrete_input_two(di2),
      .tx_holding_empty(th), .tx_shifter_empty(ts),
      .irq_enable_command(irq_en), .irq_disable_command(irq_dis),
      .flag_update(upd), .long_op(lng), .dest_msb(dm), .src_msb(sm),
      .op_result(res), .input_register_instruction(req),
      .reg_select(sel), .read_data(read_data), .read_valid(read_valid),
      .irq_enabled(irq_enabled));

   sfu_serial_sender sfu_serial_sender_i (.serial_line(rx_line));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Timer pin at 12 MHz, free of the system clock phase
   initial begin
      timer = 1'b0;
      forever #41.667 timer = ~timer;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic rd(input logic s, output logic [15:0] v);
      req = 1'b1;
      sel = s;
      @(negedge clock);
      req = 1'b0;
      check(read_valid, 16'h0001);
      v = read_data;
      @(negedge clock);
   endtask

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      {arst_n, di1, di2, th, ts, irq_en, irq_dis} = 7'h00;
      {upd, lng, dm, sm, req, sel} = 6'h00;
      res = 32'h0000_0000;
      repeat (12) @(negedge clock);
      arst_n = 1'b1;
      @(negedge clock);
      rd(SEL_STATUS, d);
      check(d, 16'h0000);
      rd(SEL_SERIAL_RECEIVE_BUFFER, d);
      check(d, 16'h0000);
      check(irq_enabled, 16'h0000);
      $display("reset test done");
      foreach (rows[i]) begin
         {upd, lng, dm, sm} = {1'b1, rows[i].lng, rows[i].dm, rows[i].sm};
         {th, ts, res} = {rows[i].th, rows[i].ts, rows[i].res};
         @(negedge clock);
         upd = 1'b0;
         rd(SEL_STATUS, d);
         check(d[15:10], rows[i].flags);
         check(d[2:1], {rows[i].th, rows[i].ts});
      end
      $display("flag rows test done");
      for (int k = 0; k < 2; k++) begin
         di1 = k[0];
         di2 = !k[0];
         repeat (6) @(negedge clock);
         rd(SEL_STATUS, d);
         check({d[8], d[3]}, {k[0], !k[0]});
      end
      $display("discrete test done");
      // Both commands at once: enable must win
      {irq_en, irq_dis} = 2'h3;
      @(negedge clock);
      {irq_en, irq_dis} = 2'h0;
      rd(SEL_STATUS, d);
      check({d[9], irq_enabled}, 16'h0003);
      irq_dis = 1'b1;
      @(negedge clock);
      irq_dis = 1'b0;
      rd(SEL_STATUS, d);
      check({d[9], irq_enabled}, 16'h0000);
      $display("irq test done");
      // Bad parity and low stop in one frame
      fork
         sfu_serial_sender_i.send(8'h35, 1'b0, 1'b0);
      join_none
      n = 0;
      do begin
         rd(SEL_STATUS, d);
         n++;
      end while (d[0] !== 1'b1 && n < 40000);
      check(d[0], 16'h0001);
      if (d[0] === 1'b1) begin
         check(d[5], 16'h0001);
         check(d[4], 16'h0001);
         check(d[7:6], 16'h0002);
         rd(SEL_SERIAL_RECEIVE_BUFFER, d);
         check(d, 16'h0035);
         rd(SEL_STATUS, d);
         check(d[0], 16'h0000);
         $display("serial frame test done");
      end
      complete_run();
   end
endmodule
